// File: rmcrc_regs.vh
// constants for the register map checksum monitor
// Contract
// - checksum runs only while the enable bit in the mode register is set
// - recompute continuously over every bit of registers 02h through 31h
// - only registers 02h through 31h contribute
// - serial feed, msb of lowest register first, lsb of highest last
// - mode register type bit selects the generator polynomial
// - 16-bit result kept in a readable checksum register
// - map-changed status flag sets whenever a pass changes an already valid checksum
// - flag clears on status read or status sent for idle command
// - each pass starts from seed ffffh
`ifndef RMCRC_REGS_VH
`define RMCRC_REGS_VH
`define RMCRC_ADDR_W 6
`define RMCRC_FIRST_ADDR 6'h02
`define RMCRC_LAST_ADDR 6'h31
`define RMCRC_SEED 16'hffff
`define RMCRC_POLY_CCITT 16'h1021
`define RMCRC_POLY_ANSI 16'h8005
`define RMCRC_OFF_MODE 12'h000
`define RMCRC_OFF_STATUS 12'h004
`define RMCRC_OFF_CHECKSUM 12'h008
`define RMCRC_OFF_MAP_BASE 12'h100
`define RMCRC_BIT_EN 0
`define RMCRC_BIT_TYPE 1
`define RMCRC_BIT_CHANGED 0
`define RMCRC_BIT_VALID 1
`endif

// File: rmcrc_map_mem.v
// register map storage, addresses 00h..3fh, 16-bit words, registered read ports
`timescale 1ns/1ps
module rmcrc_map_mem
(
    input wire clk,
    input wire wr_en,
    input wire [5:0] wr_addr,
    input wire [15:0] wr_data,
    input wire [5:0] rd_addr_a,
    output reg [15:0] rd_data_a,
    input wire [5:0] rd_addr_b,
    output reg [15:0] rd_data_b
);
    reg [15:0] mem [0:63];

    always @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data_a <= mem[rd_addr_a];
        rd_data_b <= mem[rd_addr_b];
    end
endmodule

// File: rmcrc_top.v
// register map checksum monitor with apb register access
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rmcrc_regs.vh"
module rmcrc_top
(
    input wire CLK,
    input wire SYS_RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output wire PREADY,
    output reg [31:0] PRDATA,
    output wire PSLVERR,
    input wire IDLE_STATUS_SENT
);
    localparam S_IDLE = 2'd0;
    localparam S_PRIME = 2'd1;
    localparam S_SHIFT = 2'd2;
    localparam S_DONE = 2'd3;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg en_q;
    reg type_q;
    reg changed_q;
    reg valid_q;
    reg [15:0] checksum_q;
    reg [15:0] crc_q;
    reg [15:0] crc_d;
    reg [5:0] addr_q;
    reg [5:0] addr_d;
    reg [3:0] bit_q;
    reg [3:0] bit_d;
    reg rd_wait_q;
    reg [31:0] rdata_d;
    wire [15:0] word;
    wire [15:0] mem_rd;
    wire [15:0] poly;
    wire fb;
    wire setup;
    wire access;
    wire wr_acc;
    wire rd_acc;
    wire map_hit;
    wire map_wr;
    wire [5:0] map_idx;
    wire pass_end;
    wire mismatch;

    assign setup = PSEL & ~PENABLE;
    assign access = PSEL & PENABLE & PREADY;
    assign wr_acc = access & PWRITE;
    assign rd_acc = access & ~PWRITE;
    assign map_hit = (PADDR[11:8] == 4'h1) & (PADDR[1:0] == 2'b00);
    assign map_idx = PADDR[7:2];
    assign map_wr = wr_acc & map_hit;
    // map reads need one cycle for the registered memory port
    assign PREADY = ~(PSEL & PENABLE & ~PWRITE & map_hit) | rd_wait_q;
    assign PSLVERR = 1'b0;

    rmcrc_map_mem u_mem
    (
        .clk(CLK),
        .wr_en(map_wr),
        .wr_addr(map_idx),
        .wr_data(PWDATA[15:0]),
        .rd_addr_a(addr_q),
        .rd_data_a(word),
        .rd_addr_b(map_idx),
        .rd_data_b(mem_rd)
    );

    always @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            rd_wait_q <= 1'b0;
        else
            rd_wait_q <= PSEL & PENABLE & ~PWRITE & map_hit & ~rd_wait_q;
    end

    // control and status registers
    always @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            en_q <= 1'b0;
            type_q <= 1'b0;
        end
        else if (wr_acc && PADDR == `RMCRC_OFF_MODE)
        begin
            en_q <= PWDATA[`RMCRC_BIT_EN];
            type_q <= PWDATA[`RMCRC_BIT_TYPE];
        end
    end

    always @*
    begin
        rdata_d = 32'h00000000;
        if (map_hit)
            rdata_d = {16'h0000, mem_rd};
        else if (PADDR == `RMCRC_OFF_MODE)
            rdata_d = {30'h0, type_q, en_q};
        else if (PADDR == `RMCRC_OFF_STATUS)
            rdata_d = {30'h0, valid_q, changed_q};
        else if (PADDR == `RMCRC_OFF_CHECKSUM)
            rdata_d = {16'h0000, checksum_q};
    end

    always @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            PRDATA <= 32'h00000000;
        else if (setup || (PSEL && PENABLE))
            PRDATA <= rdata_d;
    end

    // serial checksum engine
    assign poly = type_q ? `RMCRC_POLY_ANSI : `RMCRC_POLY_CCITT;
    assign fb = crc_q[15] ^ word[bit_q];
    assign pass_end = (state_q == S_DONE);
    assign mismatch = pass_end & (~valid_q | (crc_q != checksum_q));

    always @*
    begin
        state_d = state_q;
        crc_d = crc_q;
        addr_d = addr_q;
        bit_d = bit_q;
        case (state_q)
            S_IDLE:
            begin
                if (en_q)
                    state_d = S_PRIME;
                addr_d = `RMCRC_FIRST_ADDR;
            end
            S_PRIME:
            begin
                crc_d = `RMCRC_SEED;
                bit_d = 4'hf;
                state_d = S_SHIFT;
            end
            // one bit per cycle, seventeen cycles per word with the prime
            S_SHIFT:
            begin
                crc_d = {crc_q[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
                bit_d = bit_q - 4'h1;
                if (bit_q == 4'h0)
                begin
                    if (addr_q == `RMCRC_LAST_ADDR)
                        state_d = S_DONE;
                    else
                    begin
                        addr_d = addr_q + 6'h01;
                        state_d = S_PRIME;
                        crc_d = {crc_q[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
                    end
                end
            end
            S_DONE:
            begin
                addr_d = `RMCRC_FIRST_ADDR;
                state_d = en_q ? S_PRIME : S_IDLE;
            end
            default:
                state_d = S_IDLE;
        endcase
        if (!en_q)
            state_d = S_IDLE;
    end

    // prime reloads the seed only at the first word of a pass
    reg first_q;
    always @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_q <= S_IDLE;
            crc_q <= `RMCRC_SEED;
            addr_q <= `RMCRC_FIRST_ADDR;
            bit_q <= 4'hf;
            first_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            addr_q <= addr_d;
            bit_q <= bit_d;
            if (state_q == S_PRIME && !first_q)
                crc_q <= crc_q;
            else
                crc_q <= crc_d;
            if (state_q == S_PRIME)
                first_q <= 1'b0;
            else if (state_q == S_DONE || state_q == S_IDLE)
                first_q <= 1'b1;
        end
    end

    // stored checksum and map-changed flag
    always @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            checksum_q <= `RMCRC_SEED;
            valid_q <= 1'b0;
            changed_q <= 1'b0;
        end
        else
        begin
            if (pass_end)
            begin
                checksum_q <= crc_q;
                valid_q <= 1'b1;
            end
            if (mismatch && valid_q)
                changed_q <= 1'b1;
            // a status read clears only a flag that its data showed
            // a set landing between setup and access stays pending
            else if ((rd_acc && PADDR == `RMCRC_OFF_STATUS && PRDATA[`RMCRC_BIT_CHANGED]) || IDLE_STATUS_SENT)
                changed_q <= 1'b0;
        end
    end
endmodule

// File: rmcrc_checker.sv
// apb port assertions for the checksum monitor
`timescale 1ns/1ps
module rmcrc_checker
(
    input wire CLK,
    input wire SYS_RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire PREADY,
    input wire [31:0] PRDATA,
    input wire PSLVERR
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wire rd_done = PSEL && PENABLE && PREADY && !PWRITE;
    no_error_a: assert property (PSLVERR == 1'b0) else $error("slave error");
    ctrl_ready_a: assert property (PSEL && PENABLE && PADDR[11:8] == 4'h0 |-> PREADY) else $error("ctrl wait");
    map_wait_a: assert property (PSEL && $rose(PENABLE) && !PWRITE && PADDR[11:8] == 4'h1 |-> !PREADY ##1 PREADY)
        else $error("map wait");
    write_ready_a: assert property (PSEL && PENABLE && PWRITE |-> PREADY) else $error("write wait");
    sum_width_a: assert property (rd_done && PADDR == 12'h008 |-> PRDATA[31:16] == 16'h0) else $error("sum hi");
    status_width_a: assert property (rd_done && PADDR == 12'h004 |-> PRDATA[31:2] == 30'h0) else $error("st hi");
    unmapped_zero_a: assert property (rd_done && PADDR == 12'h00c |-> PRDATA == 32'h0) else $error("unmapped");
    rdata_hold_a: assert property (!PSEL |=> $stable(PRDATA)) else $error("rdata moved");
endmodule
bind rmcrc_top rmcrc_checker u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR));

// File: rmcrc_host_model.sv
// host serial side: idle command status strobe
`timescale 1ns/1ps
module rmcrc_host_model
(
    input wire clk,
    input wire send_idle,
    output reg idle_sent
);
    initial idle_sent = 1'b0;
    always @(posedge clk)
    begin
        idle_sent <= send_idle;
    end
endmodule

// File: register_map_crc_monitor_tb.sv
// self-checking bench for the checksum monitor
`timescale 1ns/1ps
module register_map_crc_monitor_tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg pen = 1'b0;
    reg pwr = 1'b0;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0;
    reg send_idle = 1'b0;
    reg [31:0] rd;
    reg [15:0] mem [0:63];
    wire pready, pslverr, idle_sent;
    wire [31:0] prdata;
    integer mismatches = 0, cmp_count = 0, cycles = 0, i;
    always #50 clk = ~clk;
    rmcrc_top dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .IDLE_STATUS_SENT(idle_sent));
    rmcrc_host_model host (.clk(clk), .send_idle(send_idle), .idle_sent(idle_sent));
    task wrap_up;
    begin
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 30000)
        begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end
    task check(input [63:0] what, input [31:0] seen, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    end
    endtask
    function [15:0] crc_of(input [15:0] poly);
        integer a, b;
        reg fb;
        begin
            crc_of = 16'hffff;
            for (a = 2; a <= 49; a = a + 1)
                for (b = 15; b >= 0; b = b - 1)
                begin
                    fb = crc_of[15] ^ mem[a][b];
                    crc_of = {crc_of[14:0], 1'b0} ^ (fb ? poly : 16'h0);
                end
        end
    endfunction
    task t_off;
    begin
        apb(0, 12'h004, 0);
        check("stat", rd, 0);
        apb(0, 12'h00c, 0);
        check("unmap", rd, 0);
        for (i = 0; i < 64; i = i + 1)
            apb(1, 12'h100 + i * 4, {16'hdead, mem[i]});
        repeat (1200) @(posedge clk);
        apb(0, 12'h008, 0);
        check("sum", rd, 32'hffff);
        apb(0, 12'h1c4, 0);
        check("map", rd, {16'h0, mem[49]});
    end
    endtask
    task t_poly(input [31:0] mode, input [15:0] poly);
    begin
        apb(1, 12'h000, mode);
        repeat (2000) @(posedge clk);
        apb(0, 12'h008, 0);
        check("sum", rd, {16'h0, crc_of(poly)});
    end
    endtask
    task t_flags;
    begin
        apb(0, 12'h004, 0);
        check("stat", rd, 3);
        apb(0, 12'h004, 0);
        check("stat", rd, 2);
        apb(0, 12'h000, 0);
        check("mode", rd, 3);
        mem[49] = ~mem[49];
        apb(1, 12'h1c4, {16'h0, mem[49]});
        apb(1, 12'h0c8, 32'h5a5a);
        apb(1, 12'h104, 32'ha5a5);
        t_poly(3, 16'h8005);
        apb(0, 12'h004, 0);
        check("stat", rd, 3);
        // word 32h lies outside the covered range
        apb(1, 12'h1c8, 32'h0f0f);
        repeat (2000) @(posedge clk);
        apb(0, 12'h004, 0);
        check("stat", rd, 2);
        mem[2] = ~mem[2];
        apb(1, 12'h108, {16'h0, mem[2]});
        t_poly(3, 16'h8005);
        @(posedge clk);
        send_idle <= 1'b1;
        @(posedge clk);
        send_idle <= 1'b0;
        repeat (3) @(posedge clk);
        apb(0, 12'h004, 0);
        check("stat", rd, 2);
        // disabled: the stored checksum must not follow a covered change
        apb(1, 12'h000, 0);
        apb(1, 12'h10c, {16'h0, ~mem[3]});
        repeat (2000) @(posedge clk);
        apb(0, 12'h008, 0);
        check("sum", rd, {16'h0, crc_of(16'h8005)});
        apb(0, 12'h004, 0);
        check("stat", rd, 2);
    end
    endtask
    initial
    begin
        for (i = 0; i < 64; i = i + 1)
            mem[i] = 16'h1357 ^ (i[15:0] * 16'h0b0d);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_off;
        t_poly(1, 16'h1021);
        apb(0, 12'h004, 0);
        check("stat", rd, 2);
        t_poly(3, 16'h8005);
        t_flags;
        wrap_up;
    end
endmodule
